// ### logic/ift_top.sv
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/10ps
module ift_top
  import ift_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic         clock_i,
  input  wire logic         srst_i,
  // Avalon-MM slave
  input  wire logic [15:0]  avs_address_i,
  input  wire logic         avs_read_i,
  input  wire logic         avs_write_i,
  input  wire logic [31:0]  avs_writedata_i,
  input  wire logic [3:0]   avs_byteenable_i,
  output logic      [31:0]  avs_readdata_o,
  output logic              avs_waitrequest_o,
  // Transmitter side
  input  wire logic         send_i,
  input  wire ift_gap_req_t gap_req_i,
  input  wire logic         tx_done_i,
  input  wire logic         tx_error_i,
  input  wire logic         low_voltage_i,
  input  wire logic         pll_locked_i,
  output logic              gap_busy_o,
  output logic              gap_done_o,
  output logic              irq_o,
  output logic              boost_o,
  output logic      [1:0]   oscillator_gain_select_o,
  output logic              lvd_enable_o,
  output logic              ready_to_send_o,
  output logic              module_soft_reset_o
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic        wait_q;
  logic        req;
  logic        wr_go;
  logic        hit_base;
  logic        hit_seed;
  logic        hit_gain;
  logic        hit_stat;
  logic [15:0] word_idx;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;

  assign req      = avs_read_i || avs_write_i;
  assign word_idx = {2'b00, avs_address_i[15:2]};
  assign wbyte    = avs_writedata_i[7:0];
  // Write lands only at the edge where waitrequest is seen low
  assign wr_go    = avs_write_i && !wait_q && avs_byteenable_i[0];

  always_comb begin
    hit_base = 1'b0;
    hit_seed = 1'b0;
    hit_gain = 1'b0;
    hit_stat = 1'b0;
    if (avs_address_i[1:0] != 2'b00) begin
      hit_base = 1'b0;
    end else if (word_idx == IDX_BASE_TIME) begin
      hit_base = 1'b1;
    end else if (word_idx == IDX_SEED) begin
      hit_seed = 1'b1;
    end else if (word_idx == IDX_GAIN_FRAME) begin
      hit_gain = 1'b1;
    end else if (word_idx == IDX_STATUS) begin
      hit_stat = 1'b1;
    end
  end

  // ----------------------------------------
  // Soft reset strobe
  // ----------------------------------------
  logic soft_q;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= wr_go && hit_stat && wbyte[BIT_SOFTRST];
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [SYNC_STAGES-1:0] lv_sync_q;
  logic [SYNC_STAGES-1:0] lk_sync_q;
  logic                   lv_q;
  logic                   lk_q;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      lv_sync_q <= '0;
      lk_sync_q <= '0;
      lv_q      <= 1'b0;
      lk_q      <= 1'b0;
    end else begin
      lv_sync_q <= {lv_sync_q[SYNC_STAGES-2:0], low_voltage_i};
      lk_sync_q <= {lk_sync_q[SYNC_STAGES-2:0], pll_locked_i};
      if (lv_sync_q[1] == lv_sync_q[2]) begin
        lv_q <= lv_sync_q[2];
      end
      if (lk_sync_q[1] == lk_sync_q[2]) begin
        lk_q <= lk_sync_q[2];
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0]        base_interval_count_q;
  logic [SEED_W-1:0] seed_q;
  logic [5:0]        frame_scaled_interval_q;
  logic              ien_q;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      base_interval_count_q <= RST_BASE_TIME;
    end else if (soft_q) begin
      base_interval_count_q <= '0;
    end else if (wr_go && hit_base) begin
      // Values 1 to 4 are not screened; software keeps to the allowed set
      base_interval_count_q <= wbyte;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      boost_o <= RST_SEED[BIT_BOOST];
      seed_q  <= RST_SEED[SEED_W-1:0];
    end else if (soft_q) begin
      boost_o <= 1'b0;
      seed_q  <= '0;
    end else if (wr_go && hit_seed) begin
      boost_o <= wbyte[BIT_BOOST];
      seed_q  <= wbyte[SEED_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      oscillator_gain_select_o <= RST_GAIN;
      frame_scaled_interval_q  <= RST_FRAME_TIMER;
    end else if (soft_q) begin
      oscillator_gain_select_o <= SOFT_GAIN;
      frame_scaled_interval_q  <= '0;
    end else if (wr_go && hit_gain) begin
      oscillator_gain_select_o <= wbyte[7:6];
      frame_scaled_interval_q  <= wbyte[5:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i || soft_q) begin
      ien_q        <= 1'b0;
      lvd_enable_o <= 1'b0;
    end else if (wr_go && hit_stat) begin
      ien_q        <= wbyte[BIT_IEN];
      lvd_enable_o <= wbyte[BIT_LVDEN];
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  ift_flags_t flags_q;
  logic       ack;

  assign ack = wr_go && hit_stat && wbyte[BIT_ACK];

  // Arriving events beat a simultaneous acknowledge
  always_ff @(posedge clock_i) begin
    if (srst_i || soft_q) begin
      flags_q <= '0;
    end else begin
      flags_q.done  <= tx_done_i || (flags_q.done && !ack);
      flags_q.error <= tx_error_i || (flags_q.error && !ack);
      flags_q.lowv  <= (lvd_enable_o && lv_q) || (flags_q.lowv && !ack);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i || soft_q) begin
      ready_to_send_o <= 1'b0;
    end else if (lk_q) begin
      ready_to_send_o <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= ien_q && (flags_q.done || flags_q.error || flags_q.lowv) && !soft_q;
    end
  end

  // ----------------------------------------
  // Read path and waitrequest
  // ----------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (hit_base) begin
      rd_byte = base_interval_count_q;
    end else if (hit_seed) begin
      rd_byte = {boost_o, seed_q};
    end else if (hit_gain) begin
      rd_byte = {oscillator_gain_select_o, frame_scaled_interval_q};
    end else if (hit_stat) begin
      // Acknowledge and soft reset bits always read zero
      rd_byte = {flags_q.done, flags_q.error, flags_q.lowv, 1'b0,
                 ien_q, lvd_enable_o, ready_to_send_o, 1'b0};
    end
  end

  // One wait cycle per access; waitrequest drops for exactly one cycle
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wait_q         <= 1'b1;
      avs_readdata_o <= '0;
    end else if (req && wait_q) begin
      wait_q         <= 1'b0;
      avs_readdata_o <= {24'h00_0000, rd_byte};
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign module_soft_reset_o = soft_q;

  // ----------------------------------------
  // Pseudo-random generator
  // ----------------------------------------
  logic              send_q;
  logic              rnd_step;
  logic [SEED_W-1:0] rnd_value;
  logic              take;

  always_ff @(posedge clock_i) begin
    if (srst_i || soft_q) begin
      send_q <= 1'b0;
    end else begin
      send_q <= send_i;
    end
  end

  assign take     = gap_req_i.start && !gap_busy_o;
  assign rnd_step = take && (gap_req_i.mode == IFT_MODE_RANDOM);

  ift_lfsr u_lfsr (
    .clock_i (clock_i),
    .clear_i (srst_i || soft_q),
    .load_i  (send_i && !send_q),
    .seed_i  (seed_q),
    .step_i  (rnd_step),
    .value_o (rnd_value)
  );

  // ----------------------------------------
  // Interval timer
  // ----------------------------------------
  typedef enum logic {
    ST_IDLE,
    ST_COUNT
  } ift_state_t;

  ift_state_t       state_q;
  logic [GAP_W-1:0] remain_q;
  logic [GAP_W-1:0] gap_len;
  logic             tick;

  always_comb begin
    case (gap_req_i.mode)
      IFT_MODE_RANDOM: gap_len = GAP_W'(rnd_value);
      IFT_MODE_FRAME:  gap_len = GAP_W'(frame_scaled_interval_q) * GAP_W'(gap_req_i.frame_num);
      default:         gap_len = GAP_W'(base_interval_count_q);
    endcase
  end

  ift_tick_div #(
    .DIV (TICK_DIV)
  ) u_tick (
    .clock_i   (clock_i),
    .srst_i    (srst_i || soft_q),
    .restart_i (take),
    .tick_o    (tick)
  );

  // Requests during a running gap are ignored; a zero length ends at once
  always_ff @(posedge clock_i) begin
    if (srst_i || soft_q) begin
      state_q    <= ST_IDLE;
      remain_q   <= '0;
      gap_busy_o <= 1'b0;
      gap_done_o <= 1'b0;
    end else begin
      gap_done_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            if (gap_len == '0) begin
              gap_done_o <= 1'b1;
            end else begin
              remain_q   <= gap_len;
              gap_busy_o <= 1'b1;
              state_q    <= ST_COUNT;
            end
          end
        end
        ST_COUNT: begin
          if (tick) begin
            if (remain_q == GAP_W'(1)) begin
              gap_done_o <= 1'b1;
              gap_busy_o <= 1'b0;
              state_q    <= ST_IDLE;
            end
            remain_q <= remain_q - 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ### logic/ift_pkg.sv
package ift_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 25;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES    = 3;

  // ----------------------------------------
  // Register map (index; byte address is four times)
  // ----------------------------------------
  localparam logic [15:0] IDX_BASE_TIME  = 16'h1834;
  localparam logic [15:0] IDX_SEED       = 16'h1835;
  localparam logic [15:0] IDX_GAIN_FRAME = 16'h1836;
  localparam logic [15:0] IDX_STATUS     = 16'h1837;

  localparam logic [7:0] RST_BASE_TIME   = 8'h80;
  localparam logic [7:0] RST_SEED        = 8'h00;
  localparam logic [1:0] RST_GAIN        = 2'h2;
  localparam logic [1:0] SOFT_GAIN       = 2'h2;
  localparam logic [5:0] RST_FRAME_TIMER = 6'h00;

  localparam int BIT_BOOST   = 7;
  localparam int BIT_DONE    = 7;
  localparam int BIT_ERROR   = 6;
  localparam int BIT_LOWV    = 5;
  localparam int BIT_ACK     = 4;
  localparam int BIT_IEN     = 3;
  localparam int BIT_LVDEN   = 2;
  localparam int BIT_RTS     = 1;
  localparam int BIT_SOFTRST = 0;

  localparam int SEED_W  = 7;
  localparam int FRAME_W = 5;
  localparam int GAP_W   = 11;

  typedef enum logic [1:0] {
    IFT_MODE_BASE,
    IFT_MODE_RANDOM,
    IFT_MODE_FRAME
  } ift_gap_mode_t;

  typedef struct packed {
    logic                 start;
    ift_gap_mode_t        mode;
    logic [FRAME_W-1:0]   frame_num;
  } ift_gap_req_t;

  typedef struct packed {
    logic done;
    logic error;
    logic lowv;
  } ift_flags_t;

endpackage

// ### logic/ift_tick_div.sv
`timescale 1ns/10ps
module ift_tick_div
  import ift_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
) (
  input  wire logic clock_i,
  input  wire logic srst_i,
  input  wire logic restart_i,
  output logic      tick_o
);

  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  // Restart aligns the first tick a full period after a gap begins
  always_ff @(posedge clock_i) begin
    if (srst_i || restart_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule

// ### logic/ift_lfsr.sv
`timescale 1ns/10ps
module ift_lfsr
  import ift_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              clear_i,
  input  wire logic              load_i,
  input  wire logic [SEED_W-1:0] seed_i,
  input  wire logic              step_i,
  output logic      [SEED_W-1:0] value_o
);

  // x^7 + x^6 + 1: XOR feedback keeps zero at zero
  always_ff @(posedge clock_i) begin
    if (clear_i) begin
      value_o <= '0;
    end else if (load_i) begin
      value_o <= seed_i;
    end else if (step_i) begin
      value_o <= {value_o[5:0], value_o[6] ^ value_o[5]};
    end
  end

endmodule

// ### bench/ift_top_sva.sv
`timescale 1ns/10ps
module ift_top_sva
  import ift_pkg::*;
(
  input wire logic         clock_i,
  input wire logic         srst_i,
  input wire logic         avs_read_i,
  input wire logic         avs_write_i,
  input wire logic [31:0]  avs_readdata_o,
  input wire logic         avs_waitrequest_o,
  input wire ift_gap_req_t gap_req_i,
  input wire logic         gap_busy_o,
  input wire logic         gap_done_o,
  input wire logic         irq_o,
  input wire logic         boost_o,
  input wire logic [1:0]   oscillator_gain_select_o,
  input wire logic         lvd_enable_o,
  input wire logic         module_soft_reset_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);

  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
  wait_back_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("wait low too long");
  rdata_top_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  done_pulse_a: assert property (gap_done_o |=> !gap_done_o)
    else $error("gap done not one cycle");
  // Soft reset aborts a gap, so no done then
  busy_end_a: assert property ($fell(gap_busy_o) && !$past(module_soft_reset_o) |-> gap_done_o)
    else $error("gap ended without done");
  gap_take_a: assert property (gap_req_i.start && !gap_busy_o && !module_soft_reset_o
    |=> gap_busy_o || gap_done_o)
    else $error("gap request not taken");
  soft_pulse_a: assert property (module_soft_reset_o |=> !module_soft_reset_o)
    else $error("soft reset pulse too long");
  soft_clear_a: assert property (module_soft_reset_o |=> !boost_o && !lvd_enable_o
    && oscillator_gain_select_o == 2'b10)
    else $error("soft reset left settings");
  irq_clear_a: assert property (module_soft_reset_o |=> ##1 !irq_o)
    else $error("irq kept after soft reset");

  cover property (gap_done_o);
  cover property (module_soft_reset_o);
  cover property ($rose(irq_o));
endmodule

bind ift_top ift_top_sva i_ift_top_sva (.clock_i, .srst_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o, .gap_req_i, .gap_busy_o, .gap_done_o, .irq_o, .boost_o, .oscillator_gain_select_o,
  .lvd_enable_o, .module_soft_reset_o);

// ### bench/tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb;
  import ift_pkg::*;
  localparam int          TD     = 8;
  localparam logic [15:0] A_BASE = 16'h60d0;
  localparam logic [15:0] A_SEED = 16'h60d4;
  localparam logic [15:0] A_GAIN = 16'h60d8;
  localparam logic [15:0] A_STAT = 16'h60dc;
  logic         clock_i, srst_i, avs_read_i, avs_write_i, send_i;
  logic         tx_done_i, tx_error_i, low_voltage_i, pll_locked_i;
  logic [15:0]  avs_address_i;
  logic [31:0]  avs_writedata_i, avs_readdata_o, q;
  logic         avs_waitrequest_o, gap_busy_o, gap_done_o, irq_o, boost_o;
  logic         lvd_enable_o, ready_to_send_o, module_soft_reset_o;
  logic [1:0]   oscillator_gain_select_o;
  logic [6:0]   v;
  ift_gap_req_t gap_req_i;
  int           mismatches, n_compared, c;

  ift_top #(.TICK_DIV(TD)) i_ift_top (.clock_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o, .send_i, .gap_req_i,
    .tx_done_i, .tx_error_i, .low_voltage_i, .pll_locked_i, .gap_busy_o, .gap_done_o, .irq_o, .boost_o,
    .oscillator_gain_select_o, .lvd_enable_o, .ready_to_send_o, .module_soft_reset_o);

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----
  // Bus and gap tasks
  // ----
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    avs_address_i   <= a;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    avs_writedata_i <= {24'h00_0000, d};
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    // Idle edge so the next request is not raised in the same step
    @(posedge clock_i);
    if (n >= 20) begin
      mismatches++;
      complete_run();
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    acc(a, 1'b0, 8'h00);
    `CHK("readdata", {24'h00_0000, e}, q)
  endtask

  task automatic gap(input ift_gap_mode_t m, input logic [4:0] f, input int n);
    int e;
    // Zero length ends at the take edge; otherwise registered tick and done add two edges
    e = (n == 0) ? 1 : n * TD + 2;
    gap_req_i <= '{1'b1, m, f};
    @(posedge clock_i);
    gap_req_i <= '{1'b0, m, f};
    c = 0;
    do begin
      @(posedge clock_i);
      c++;
    end while (gap_done_o !== 1'b1 && c < 3000);
    `CHK("gap cycles", e, c)
    if (c >= 3000) complete_run();
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    srst_i = 1'b1;
    {avs_read_i, avs_write_i, send_i, tx_done_i, tx_error_i, low_voltage_i, pll_locked_i} = '0;
    avs_address_i = '0;
    avs_writedata_i = '0;
    gap_req_i = '0;
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    rd(A_BASE, 8'h80);
    rd(A_SEED, 8'h00);
    rd(A_GAIN, 8'h80);
    rd(A_STAT, 8'h00);
    rd(16'h6000, 8'h00);
    // Misaligned write must be refused
    acc(16'h60d1, 1'b1, 8'h55);
    rd(A_BASE, 8'h80);
    `CHK("gain", 2'b10, oscillator_gain_select_o)
    $display("test reset_values done");
    acc(A_BASE, 1'b1, 8'h05);
    gap(IFT_MODE_BASE, 5'd0, 5);
    acc(A_BASE, 1'b1, 8'h00);
    gap(IFT_MODE_BASE, 5'd0, 0);
    acc(A_GAIN, 1'b1, 8'h83);
    gap(IFT_MODE_FRAME, 5'd2, 6);
    $display("test fixed_gaps done");
    acc(A_SEED, 1'b1, 8'hc1);
    `CHK("boost", 1'b1, boost_o)
    send_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    v = 7'h41;
    repeat (3) begin
      gap(IFT_MODE_RANDOM, 5'd0, int'(v));
      v = {v[5:0], v[6] ^ v[5]};
    end
    rd(A_SEED, 8'hc1);
    // Seed written while send stays high must not reload
    acc(A_SEED, 1'b1, 8'h80);
    gap(IFT_MODE_RANDOM, 5'd0, int'(v));
    send_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    send_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    repeat (2) gap(IFT_MODE_RANDOM, 5'd0, 0);
    $display("test random_gaps done");
    acc(A_STAT, 1'b1, 8'h0c);
    `CHK("lvd_enable", 1'b1, lvd_enable_o)
    tx_done_i <= 1'b1;
    @(posedge clock_i);
    tx_done_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    `CHK("irq", 1'b1, irq_o)
    rd(A_STAT, 8'h8c);
    acc(A_STAT, 1'b1, 8'h1c);
    rd(A_STAT, 8'h0c);
    `CHK("irq", 1'b0, irq_o)
    tx_error_i <= 1'b1;
    low_voltage_i <= 1'b1;
    pll_locked_i <= 1'b1;
    @(posedge clock_i);
    tx_error_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    low_voltage_i <= 1'b0;
    pll_locked_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    `CHK("ready", 1'b1, ready_to_send_o)
    // Done flag was acknowledged before; error, low voltage and ready to send are new
    rd(A_STAT, 8'h6e);
    `CHK("irq", 1'b1, irq_o)
    acc(A_STAT, 1'b1, 8'h1c);
    rd(A_STAT, 8'h0e);
    $display("test flags done");
    acc(A_STAT, 1'b1, 8'h01);
    rd(A_BASE, 8'h00);
    rd(A_SEED, 8'h00);
    rd(A_GAIN, 8'h80);
    rd(A_STAT, 8'h00);
    `CHK("boost", 1'b0, boost_o)
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    rd(A_BASE, 8'h80);
    $display("test soft_reset done");
    complete_run();
  end
endmodule
